/* logic/ifpc_cfg.svh */
`ifndef IFPC_CFG_SVH
`define IFPC_CFG_SVH
// register indices; byte address is four times the index
`define IFPC_IDX_CTRL       8'h9F
`define IFPC_IDX_ADDR_L     8'hAC
`define IFPC_IDX_ADDR_H     8'hAD
`define IFPC_IDX_DATA       8'hAE
`define IFPC_IDX_MODE       8'hAF
`define IFPC_IDX_PWR        8'hF0
`define IFPC_IDX_W          8
`define IFPC_IDX_LSB        2
`define IFPC_APB_AW         12
// flash_program_control fields
`define IFPC_CTRL_RST_BIT   7
`define IFPC_CTRL_EXEC_BIT  5
`define IFPC_CTRL_LOADER_FETCH_SELECT_BIT 1
`define IFPC_CTRL_ENP_BIT   0
// flash_operation_mode fields
`define IFPC_MODE_BANK_BIT  6
`define IFPC_MODE_OE_BIT    5
`define IFPC_MODE_CE_BIT    4
`define IFPC_MODE_OP_HI     3
`define IFPC_MODE_OP_LO     0
// power control field holding the idle request
`define IFPC_PWR_IDLE_BIT   1
// operation codes
`define IFPC_OP_READ        4'h0
`define IFPC_OP_PROG        4'h1
`define IFPC_OP_ERASE       4'h2
// reset values
`define IFPC_RST_BYTE       8'h00
`define IFPC_RST_MODE       8'h30
`define IFPC_RST_WORD       32'h0000_0000
`endif

/* logic/ifpc_pkg.sv */
`include "ifpc_cfg.svh"

package ifpc_pkg;
   typedef logic [7:0] ifpc_byte_t;

   typedef enum logic [1:0] {
      IFPC_S_IDLE   = 2'b00,
      IFPC_S_ACCESS = 2'b01,
      IFPC_S_FINISH = 2'b10
   } ifpc_seq_e;

   typedef enum logic [3:0] {
      IFPC_OPC_READ  = `IFPC_OP_READ,
      IFPC_OPC_PROG  = `IFPC_OP_PROG,
      IFPC_OPC_ERASE = `IFPC_OP_ERASE
   } ifpc_op_e;
endpackage : ifpc_pkg

/* logic/ifpc_flash_seq.sv */
`include "ifpc_cfg.svh"

module ifpc_flash_seq #(
   parameter int ADDR_W = 16
) (
   // clock and reset
   input  wire logic              clk_in,
   input  wire logic              rstn_in,
   // operation request
   input  wire logic              start_in,
   input  wire logic [3:0]        op_in,
   input  wire logic              bank_in,
   input  wire logic [ADDR_W-1:0] addr_in,
   input  wire logic [7:0]        wdata_in,
   input  wire logic              oe_n_in,
   input  wire logic              ce_n_in,
   output logic                   busy_out,
   output logic                   done_out,
   output logic                   rdata_valid_out,
   output logic [7:0]             rdata_out,
   // flash array
   output logic                   flash_req_out,
   output logic [3:0]             flash_op_out,
   output logic                   flash_bank_out,
   output logic [ADDR_W-1:0]      flash_addr_out,
   output logic [7:0]             flash_wdata_out,
   output logic                   flash_oe_n_out,
   output logic                   flash_ce_n_out,
   input  wire logic              flash_done_in,
   input  wire logic [7:0]        flash_rdata_in
);
   import ifpc_pkg::*;

   ifpc_seq_e state_q;
   logic      valid_op;

   // a disabled chip or an unknown code finishes without touching the array
   assign valid_op = !ce_n_in && (op_in == `IFPC_OP_READ || op_in == `IFPC_OP_PROG
                                  || op_in == `IFPC_OP_ERASE);

   always_ff @(posedge clk_in) begin
      if (!rstn_in) begin
         state_q <= IFPC_S_IDLE;
      end else begin
         case (state_q)
            IFPC_S_IDLE: begin
               if (start_in) begin
                  state_q <= valid_op ? IFPC_S_ACCESS : IFPC_S_FINISH;
               end
            end
            IFPC_S_ACCESS: begin
               if (flash_done_in) begin
                  state_q <= IFPC_S_FINISH;
               end
            end
            IFPC_S_FINISH: state_q <= IFPC_S_IDLE;
            default:       state_q <= IFPC_S_IDLE;
         endcase
      end
   end

   always_ff @(posedge clk_in) begin
      if (!rstn_in) begin
         flash_op_out    <= `IFPC_OP_READ;
         flash_bank_out  <= 1'b0;
         flash_addr_out  <= '0;
         flash_wdata_out <= `IFPC_RST_BYTE;
         flash_oe_n_out  <= 1'b1;
         flash_ce_n_out  <= 1'b1;
      end else if (state_q == IFPC_S_IDLE && start_in) begin
         flash_op_out    <= op_in;
         flash_bank_out  <= bank_in;
         // whole-bank erase takes no address
         flash_addr_out  <= (op_in == `IFPC_OP_ERASE) ? '0 : addr_in;
         flash_wdata_out <= wdata_in;
         flash_oe_n_out  <= oe_n_in;
         flash_ce_n_out  <= ce_n_in;
      end else if (state_q == IFPC_S_FINISH) begin
         flash_ce_n_out  <= 1'b1;
      end
   end

   always_ff @(posedge clk_in) begin
      if (!rstn_in) begin
         rdata_out       <= `IFPC_RST_BYTE;
         rdata_valid_out <= 1'b0;
      end else begin
         rdata_valid_out <= 1'b0;
         if (state_q == IFPC_S_ACCESS && flash_done_in
             && flash_op_out == `IFPC_OP_READ) begin
            rdata_out       <= flash_rdata_in;
            rdata_valid_out <= 1'b1;
         end
      end
   end

   assign flash_req_out = (state_q == IFPC_S_ACCESS);
   assign busy_out      = (state_q != IFPC_S_IDLE);
   assign done_out      = (state_q == IFPC_S_FINISH);
endmodule // ifpc_flash_seq

/* logic/ifpc_program_control.sv */
// Overview of operation
// - Writing one to soft reset bit resets block like pin, all but reboot-mode synchroniser; bit self-clears.
// - Reading soft reset bit returns one while in hardware reboot mode.
// - Execution bank status is read-only: one for loader, zero for application.
// - Loader fetch select high makes instruction fetch come from loader bank.
// - Program mode enable places the device in in-system programming mode.
// - In programming mode, erase/program/read follow address, data, mode registers.
// - In programming mode, idle request starts the flash operation, not true idle.
// - Clearing program mode enable restores normal idle behaviour.
// - Flash byte address is high byte and low byte registers combined.
// - Program data enter and read data return through the data buffer register.
// - Bank select zero targets application bank, one targets loader bank.
// - With chip enable low, code 0010 erases bank, 0001 programs, 0000 reads.
`include "ifpc_cfg.svh"

module ifpc_program_control #(
   parameter int ADDR_W = 16
) (
   // clock and reset
   input  wire logic                      core_clk_in,
   input  wire logic                      rstn_in,
   // apb slave
   input  wire logic                      psel_in,
   input  wire logic                      penable_in,
   input  wire logic                      pwrite_in,
   input  wire logic [`IFPC_APB_AW-1:0]   paddr_in,
   input  wire logic [31:0]               pwdata_in,
   input  wire logic [3:0]                pstrb_in,
   output logic [31:0]                    prdata_out,
   output logic                           pready_out,
   output logic                           pslverr_out,
   // system status and control
   input  wire logic                      reboot_mode_in,
   input  wire logic                      wake_in,
   output logic                           device_reset_out,
   output logic                           fetch_loader_out,
   output logic                           cpu_hold_out,
   output logic                           cpu_idle_out,
   // flash array
   output logic                           flash_req_out,
   output logic [3:0]                     flash_op_out,
   output logic                           flash_bank_out,
   output logic [ADDR_W-1:0]              flash_addr_out,
   output logic [7:0]                     flash_wdata_out,
   output logic                           flash_oe_n_out,
   output logic                           flash_ce_n_out,
   input  wire logic                      flash_done_in,
   input  wire logic [7:0]                flash_rdata_in
);
   import ifpc_pkg::*;

   // the two address byte registers cover exactly sixteen bits
   if (ADDR_W != 16) begin : g_addr_w_check
      $error("ifpc_program_control: ADDR_W must be 16");
   end

   function automatic logic reg_hit(
      input logic [`IFPC_APB_AW-1:0] addr,
      input logic [`IFPC_IDX_W-1:0]  idx
   );
      logic [`IFPC_APB_AW-`IFPC_IDX_LSB-1:0] word;
      word    = addr[`IFPC_APB_AW-1:`IFPC_IDX_LSB];
      reg_hit = (word == (`IFPC_APB_AW-`IFPC_IDX_LSB)'(idx))
                && (addr[`IFPC_IDX_LSB-1:0] == '0);
   endfunction

   // soft reset and block reset
   logic       soft_rst_q;
   logic       blk_rstn;

   // reboot mode synchroniser
   logic       reboot_meta_q;
   logic       reboot_sync_q;

   // control register bits
   logic       loader_fetch_select_q;
   logic       enp_q;

   // address, data, mode registers
   ifpc_byte_t addr_byte_q [2];
   ifpc_byte_t data_q;
   ifpc_byte_t mode_q;

   // idle request and operation tracking
   logic       idle_req_q;
   logic       isp_op_q;

   // bus decode
   logic       setup;
   logic       access;
   logic       wr_en;
   logic       mapped;
   logic       hit_ctrl;
   logic       hit_addr_l;
   logic       hit_addr_h;
   logic       hit_data;
   logic       hit_mode;
   logic       hit_pwr;
   ifpc_byte_t wbyte;
   ifpc_byte_t rd_byte;

   // sequencer hookup
   logic       seq_start;
   logic       seq_busy;
   logic       seq_done;
   logic       seq_rvalid;
   ifpc_byte_t seq_rdata;
   logic       idle_wr_set;

   assign blk_rstn = rstn_in && !soft_rst_q;

   // ---------------- apb decode ----------------
   assign setup      = psel_in && !penable_in;
   assign access     = psel_in && penable_in;
   assign hit_ctrl   = reg_hit(paddr_in, `IFPC_IDX_CTRL);
   assign hit_addr_l = reg_hit(paddr_in, `IFPC_IDX_ADDR_L);
   assign hit_addr_h = reg_hit(paddr_in, `IFPC_IDX_ADDR_H);
   assign hit_data   = reg_hit(paddr_in, `IFPC_IDX_DATA);
   assign hit_mode   = reg_hit(paddr_in, `IFPC_IDX_MODE);
   assign hit_pwr    = reg_hit(paddr_in, `IFPC_IDX_PWR);
   assign mapped     = hit_ctrl || hit_addr_l || hit_addr_h
                       || hit_data || hit_mode || hit_pwr;
   // only byte lane 0 carries register data
   assign wr_en      = access && pwrite_in && mapped && pstrb_in[0];
   assign wbyte      = pwdata_in[7:0];

   // zero wait states: read data is staged during the setup cycle
   assign pready_out  = access;
   assign pslverr_out = access && !mapped;

   // ---------------- soft reset ----------------
   // held one cycle; the rest of the chip stretches it if it needs more
   always_ff @(posedge core_clk_in) begin
      if (!rstn_in) begin
         soft_rst_q <= 1'b0;
      end else begin
         soft_rst_q <= !soft_rst_q && wr_en && hit_ctrl
                       && wbyte[`IFPC_CTRL_RST_BIT];
      end
   end

   assign device_reset_out = soft_rst_q;

   // ---------------- reboot mode pin ----------------
   always_ff @(posedge core_clk_in) begin
      if (!rstn_in) begin
         reboot_meta_q <= 1'b0;
         reboot_sync_q <= 1'b0;
      end else begin
         reboot_meta_q <= reboot_mode_in;
         reboot_sync_q <= reboot_meta_q;
      end
   end

   // ---------------- control register ----------------
   always_ff @(posedge core_clk_in) begin
      if (!blk_rstn) begin
         loader_fetch_select_q <= 1'b0;
         enp_q   <= 1'b0;
      end else if (wr_en && hit_ctrl) begin
         loader_fetch_select_q <= wbyte[`IFPC_CTRL_LOADER_FETCH_SELECT_BIT];
         enp_q   <= wbyte[`IFPC_CTRL_ENP_BIT];
      end
   end

   // fetch bank follows the select bit; status reports the same level
   assign fetch_loader_out = loader_fetch_select_q;

   // ---------------- address registers ----------------
   genvar gi;
   generate
      for (gi = 0; gi < 2; gi++) begin : g_addr
         logic hit_this;
         assign hit_this = (gi == 0) ? hit_addr_l : hit_addr_h;
         always_ff @(posedge core_clk_in) begin
            if (!blk_rstn) begin
               addr_byte_q[gi] <= `IFPC_RST_BYTE;
            end else if (wr_en && hit_this) begin
               addr_byte_q[gi] <= wbyte;
            end
         end
      end
   endgenerate

   // ---------------- data buffer ----------------
   // a read result wins over a bus write in the same cycle
   always_ff @(posedge core_clk_in) begin
      if (!blk_rstn) begin
         data_q <= `IFPC_RST_BYTE;
      end else if (seq_rvalid) begin
         data_q <= seq_rdata;
      end else if (wr_en && hit_data) begin
         data_q <= wbyte;
      end
   end

   // ---------------- operation mode ----------------
   // output enable is stored as written; software owns its polarity per op
   always_ff @(posedge core_clk_in) begin
      if (!blk_rstn) begin
         mode_q <= `IFPC_RST_MODE;
      end else if (wr_en && hit_mode) begin
         mode_q <= wbyte;
      end
   end

   // ---------------- idle request ----------------
   assign idle_wr_set = wr_en && hit_pwr && wbyte[`IFPC_PWR_IDLE_BIT];
   // a second request is not accepted while an operation is in flight
   assign seq_start   = idle_wr_set && enp_q && !isp_op_q && !seq_busy;

   always_ff @(posedge core_clk_in) begin
      if (!blk_rstn) begin
         idle_req_q <= 1'b0;
      end else if (idle_wr_set) begin
         idle_req_q <= 1'b1;
      end else if (isp_op_q && seq_done) begin
         idle_req_q <= 1'b0;
      end else if (!isp_op_q && wake_in) begin
         idle_req_q <= 1'b0;
      end else if (wr_en && hit_pwr) begin
         idle_req_q <= 1'b0;
      end
   end

   // operation keeps running even if program mode is dropped meanwhile
   always_ff @(posedge core_clk_in) begin
      if (!blk_rstn) begin
         isp_op_q <= 1'b0;
      end else if (seq_start) begin
         isp_op_q <= 1'b1;
      end else if (seq_done) begin
         isp_op_q <= 1'b0;
      end
   end

   assign cpu_hold_out = isp_op_q;
   assign cpu_idle_out = idle_req_q && !isp_op_q && !seq_start;

   // ---------------- read mux ----------------
   always_comb begin
      rd_byte = `IFPC_RST_BYTE;
      if (hit_ctrl) begin
         rd_byte[`IFPC_CTRL_RST_BIT]   = reboot_sync_q;
         rd_byte[`IFPC_CTRL_EXEC_BIT]  = fetch_loader_out;
         rd_byte[`IFPC_CTRL_LOADER_FETCH_SELECT_BIT] = loader_fetch_select_q;
         rd_byte[`IFPC_CTRL_ENP_BIT]   = enp_q;
      end else if (hit_addr_l) begin
         rd_byte = addr_byte_q[0];
      end else if (hit_addr_h) begin
         rd_byte = addr_byte_q[1];
      end else if (hit_data) begin
         rd_byte = data_q;
      end else if (hit_mode) begin
         rd_byte = mode_q;
      end else if (hit_pwr) begin
         rd_byte[`IFPC_PWR_IDLE_BIT] = idle_req_q;
      end
   end

   always_ff @(posedge core_clk_in) begin
      if (!blk_rstn) begin
         prdata_out <= `IFPC_RST_WORD;
      end else if (setup && !pwrite_in) begin
         prdata_out <= {24'h000000, rd_byte};
      end
   end

   // ---------------- flash sequencer ----------------
   ifpc_flash_seq #(
      .ADDR_W (ADDR_W)
   ) u_seq (
      .clk_in          (core_clk_in),
      .rstn_in         (blk_rstn),
      .start_in        (seq_start),
      .op_in           (mode_q[`IFPC_MODE_OP_HI:`IFPC_MODE_OP_LO]),
      .bank_in         (mode_q[`IFPC_MODE_BANK_BIT]),
      .addr_in         ({addr_byte_q[1], addr_byte_q[0]}),
      .wdata_in        (data_q),
      .oe_n_in         (mode_q[`IFPC_MODE_OE_BIT]),
      .ce_n_in         (mode_q[`IFPC_MODE_CE_BIT]),
      .busy_out        (seq_busy),
      .done_out        (seq_done),
      .rdata_valid_out (seq_rvalid),
      .rdata_out       (seq_rdata),
      .flash_req_out   (flash_req_out),
      .flash_op_out    (flash_op_out),
      .flash_bank_out  (flash_bank_out),
      .flash_addr_out  (flash_addr_out),
      .flash_wdata_out (flash_wdata_out),
      .flash_oe_n_out  (flash_oe_n_out),
      .flash_ce_n_out  (flash_ce_n_out),
      .flash_done_in   (flash_done_in),
      .flash_rdata_in  (flash_rdata_in)
   );
endmodule // ifpc_program_control

/* tb/ifpc_program_control_sva.sv */
`include "ifpc_cfg.svh"

module ifpc_program_control_sva #(
   parameter int ADDR_W = 16
) (
   // clock and reset
   input wire logic                    core_clk_in,
   input wire logic                    rstn_in,
   // apb
   input wire logic                    psel_in,
   input wire logic                    penable_in,
   input wire logic                    pwrite_in,
   input wire logic [`IFPC_APB_AW-1:0] paddr_in,
   input wire logic [31:0]             pwdata_in,
   input wire logic [3:0]              pstrb_in,
   input wire logic [31:0]             prdata_out,
   // status and flash
   input wire logic                    device_reset_out,
   input wire logic                    fetch_loader_out,
   input wire logic                    cpu_hold_out,
   input wire logic                    cpu_idle_out,
   input wire logic                    flash_req_out,
   input wire logic [3:0]              flash_op_out,
   input wire logic [ADDR_W-1:0]       flash_addr_out,
   input wire logic                    flash_ce_n_out,
   input wire logic                    flash_done_in
);
   import ifpc_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge core_clk_in); endclocking
   default disable iff (!rstn_in);
   logic ctrl_acc;
   assign ctrl_acc = psel_in && penable_in && (paddr_in == {2'h0, `IFPC_IDX_CTRL, 2'h0});
   sequence ctrl_wr_s;
      ctrl_acc && pwrite_in && pstrb_in[0];
   endsequence
   sequence op_end_s;
      flash_req_out && flash_done_in ##1 !flash_req_out;
   endsequence
   chk_soft_rst_pulse: assert property (ctrl_wr_s ##0 pwdata_in[7] |=> device_reset_out
      ##1 !device_reset_out) else $error("soft reset pulse wrong");
   chk_rst_clears_state: assert property (device_reset_out |=> !fetch_loader_out
      && !cpu_hold_out) else $error("soft reset left state set");
   chk_fetch_select: assert property (ctrl_wr_s ##0 !pwdata_in[7] |=>
      fetch_loader_out == $past(pwdata_in[1])) else $error("fetch select not taken");
   chk_exec_status: assert property (ctrl_acc && !pwrite_in |->
      prdata_out[5] == fetch_loader_out) else $error("exec bank status wrong");
   chk_hold_on_start: assert property ($rose(flash_req_out) |-> cpu_hold_out)
      else $error("cpu not held at op start");
   chk_no_true_idle: assert property (cpu_hold_out |-> !cpu_idle_out)
      else $error("true idle during flash op");
   chk_req_held: assert property (flash_req_out && !flash_done_in |=> flash_req_out)
      else $error("flash request dropped early");
   chk_op_finish: assert property (op_end_s |=> !cpu_hold_out)
      else $error("hold not released after op");
   chk_erase_addr: assert property (flash_req_out && flash_op_out == `IFPC_OP_ERASE |->
      flash_addr_out == '0) else $error("erase address not zero");
   chk_ce_gate: assert property (flash_req_out |-> !flash_ce_n_out)
      else $error("request without chip enable");
   chk_cmd_stable: assert property (flash_req_out && $past(flash_req_out) |->
      $stable(flash_addr_out) && $stable(flash_op_out)) else $error("command moved mid-op");
endmodule // ifpc_program_control_sva

/* tb/ifpc_flash_model.sv */
module ifpc_flash_model (
   // clock and reset
   input  wire logic        clk_in,
   input  wire logic        rstn_in,
   // answer latency
   input  wire logic [2:0]  delay_in,
   // array side
   input  wire logic        req_in,
   input  wire logic [3:0]  op_in,
   input  wire logic        bank_in,
   input  wire logic [15:0] addr_in,
   input  wire logic [7:0]  wdata_in,
   output logic             done_out,
   output logic [7:0]       rdata_out
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] app_mem [int];
   logic [7:0] ldr_mem [int];
   logic [2:0] cnt_q;
   logic       busy_q;
   logic       sent_q;
   logic       fire;
   function automatic logic [7:0] peek(input logic b, input logic [15:0] a);
      if (b) return ldr_mem.exists(a) ? ldr_mem[a] : 8'hFF;
      return app_mem.exists(a) ? app_mem[a] : 8'hFF;
   endfunction
   initial rdata_out = 8'hA5;
   assign fire = rstn_in && busy_q && !sent_q && cnt_q == 3'h0;
   always @(posedge clk_in) begin
      done_out  <= fire;
      // outside the done pulse the bus toggles so no stale byte can pass
      rdata_out <= fire ? peek(bank_in, addr_in) : ~rdata_out;
      if (fire && op_in == 4'h2 && bank_in) ldr_mem.delete();
      if (fire && op_in == 4'h2 && !bank_in) app_mem.delete();
      // programming only clears bits, as a real array does
      if (fire && op_in == 4'h1 && bank_in) ldr_mem[addr_in] = peek(1'b1, addr_in) & wdata_in;
      if (fire && op_in == 4'h1 && !bank_in) app_mem[addr_in] = peek(1'b0, addr_in) & wdata_in;
      if (!rstn_in) begin
         busy_q <= 1'b0;
         sent_q <= 1'b0;
      end else if (req_in && !busy_q) begin
         busy_q <= 1'b1;
         cnt_q  <= delay_in;
      end else if (busy_q && cnt_q != 3'h0) begin
         cnt_q <= cnt_q - 3'h1;
      end else if (fire) begin
         sent_q <= 1'b1;
      end else if (busy_q && sent_q && !req_in) begin
         busy_q <= 1'b0;
         sent_q <= 1'b0;
      end
   end
endmodule // ifpc_flash_model

/* tb/isp_flash_program_control_test.sv */
`include "ifpc_cfg.svh"

module isp_flash_program_control_test;
   timeunit 1ns;
   timeprecision 1ps;
   import ifpc_pkg::*;
   logic        core_clk_in, rstn_in, psel_in, penable_in, pwrite_in, reboot_mode_in, wake_in;
   logic        pready_out, pslverr_out, device_reset_out, fetch_loader_out, cpu_hold_out;
   logic        cpu_idle_out, flash_req_out, flash_bank_out, flash_oe_n_out, flash_ce_n_out;
   logic        flash_done_in, e;
   logic [11:0] paddr_in;
   logic [31:0] pwdata_in, prdata_out, d;
   logic [3:0]  pstrb_in, flash_op_out;
   logic [15:0] flash_addr_out, r;
   logic [15:0] lfsr_q = 16'h0009;
   logic [7:0]  flash_wdata_out, flash_rdata_in;
   logic [2:0]  delay;
   logic [7:0]  sh_app [int];
   logic [7:0]  sh_ldr [int];
   int          error_cnt = 0, compares = 0, req_cnt = 0, rst_cnt = 0, n;

   ifpc_program_control #(.ADDR_W(16)) ifpc_program_control_inst (
      .core_clk_in, .rstn_in, .psel_in, .penable_in, .pwrite_in, .paddr_in, .pwdata_in,
      .pstrb_in, .prdata_out, .pready_out, .pslverr_out, .reboot_mode_in, .wake_in,
      .device_reset_out, .fetch_loader_out, .cpu_hold_out, .cpu_idle_out, .flash_req_out,
      .flash_op_out, .flash_bank_out, .flash_addr_out, .flash_wdata_out, .flash_oe_n_out,
      .flash_ce_n_out, .flash_done_in, .flash_rdata_in);
   ifpc_flash_model ifpc_flash_model_inst (
      .clk_in(core_clk_in), .rstn_in, .delay_in(delay), .req_in(flash_req_out),
      .op_in(flash_op_out), .bank_in(flash_bank_out), .addr_in(flash_addr_out),
      .wdata_in(flash_wdata_out), .done_out(flash_done_in), .rdata_out(flash_rdata_in));

   initial begin
      core_clk_in = 1'b0;
      forever #12.5 core_clk_in = ~core_clk_in;
   end
   always @(posedge core_clk_in) begin
      if (flash_req_out === 1'b1 && flash_done_in === 1'b1) req_cnt++;
      if (device_reset_out === 1'b1) rst_cnt++;
   end

   task automatic give_verdict();
      if (error_cnt == 0 && compares > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         error_cnt++;
         $display("ERROR at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   function automatic logic [15:0] lfsr_next(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   task automatic rnd(output logic [15:0] v);
      lfsr_q = lfsr_next(lfsr_q);
      v = lfsr_q;
      delay <= lfsr_q[10:8];
   endtask
   function automatic logic [7:0] expect_byte(input logic b, input logic [15:0] a);
      if (b) return sh_ldr.exists(a) ? sh_ldr[a] : 8'hFF;
      return sh_app.exists(a) ? sh_app[a] : 8'hFF;
   endfunction
   // one idle cycle after each transfer keeps every signal to one assignment a step
   task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] wd,
                      input logic [3:0] st, output logic [31:0] rd, output logic err);
      int k;
      psel_in   <= 1'b1;
      pwrite_in <= wr;
      paddr_in  <= {2'h0, idx, 2'h0};
      pwdata_in <= {24'h0, wd};
      pstrb_in  <= st;
      @(posedge core_clk_in);
      penable_in <= 1'b1;
      for (k = 0; k < 16; k++) begin
         @(posedge core_clk_in);
         if (pready_out === 1'b1) break;
      end
      if (k == 16) error_cnt++;
      if (k == 16) give_verdict();
      rd = prdata_out;
      err = pslverr_out;
      psel_in    <= 1'b0;
      penable_in <= 1'b0;
      @(posedge core_clk_in);
   endtask
   task automatic wr(input logic [7:0] idx, input logic [7:0] wd);
      apb(1'b1, idx, wd, 4'hF, d, e);
   endtask
   task automatic rd_chk(input logic [7:0] idx, input logic [7:0] exp);
      apb(1'b0, idx, 8'h00, 4'hF, d, e);
      check(d, {24'h0, exp});
   endtask
   task automatic flash_op(input logic b, input logic ce, input logic [3:0] op,
                           input logic [15:0] a, input logic [7:0] wd);
      int k;
      wr(`IFPC_IDX_ADDR_L, a[7:0]);
      wr(`IFPC_IDX_ADDR_H, a[15:8]);
      wr(`IFPC_IDX_DATA, wd);
      wr(`IFPC_IDX_MODE, {1'b0, b, op != `IFPC_OP_READ, ce, op});
      wr(`IFPC_IDX_PWR, 8'h02);
      if (!ce) check(cpu_hold_out, 1'b1);
      check(flash_oe_n_out, op != `IFPC_OP_READ);
      for (k = 0; cpu_hold_out !== 1'b0 && k < 64; k++) @(posedge core_clk_in);
      if (k == 64) error_cnt++;
      if (k == 64) give_verdict();
      rd_chk(`IFPC_IDX_PWR, 8'h00);
      if (ce || op > `IFPC_OP_ERASE) return;
      if (op == `IFPC_OP_READ) rd_chk(`IFPC_IDX_DATA, expect_byte(b, a));
      if (op == `IFPC_OP_PROG && b) sh_ldr[a] = expect_byte(b, a) & wd;
      if (op == `IFPC_OP_PROG && !b) sh_app[a] = expect_byte(b, a) & wd;
      if (op == `IFPC_OP_ERASE && b) sh_ldr.delete();
      if (op == `IFPC_OP_ERASE && !b) sh_app.delete();
   endtask

   initial begin
      repeat (100000) @(posedge core_clk_in);
      error_cnt++;
      give_verdict();
   end
   initial begin
      {rstn_in, psel_in, penable_in, pwrite_in, reboot_mode_in, wake_in} = 6'h00;
      paddr_in = 12'h000;
      pwdata_in = 32'h0;
      pstrb_in = 4'h0;
      delay = 3'h0;
      repeat (8) @(posedge core_clk_in);
      rstn_in <= 1'b1;
      @(posedge core_clk_in);
      rd_chk(`IFPC_IDX_CTRL, 8'h00);
      rd_chk(`IFPC_IDX_MODE, `IFPC_RST_MODE);
      apb(1'b0, 8'h10, 8'h00, 4'hF, d, e);
      check(e, 1'b1);
      apb(1'b1, `IFPC_IDX_ADDR_L, 8'h5A, 4'h0, d, e);
      rd_chk(`IFPC_IDX_ADDR_L, 8'h00);
      wr(`IFPC_IDX_CTRL, 8'h20);
      rd_chk(`IFPC_IDX_CTRL, 8'h00);
      wr(`IFPC_IDX_CTRL, 8'h02);
      rd_chk(`IFPC_IDX_CTRL, 8'h22);
      check(fetch_loader_out, 1'b1);
      reboot_mode_in <= 1'b1;
      repeat (3) @(posedge core_clk_in);
      rd_chk(`IFPC_IDX_CTRL, 8'hA2);
      reboot_mode_in <= 1'b0;
      wr(`IFPC_IDX_CTRL, 8'h01);
      for (int b = 0; b < 2; b++) begin
         rnd(r);
         flash_op(b[0], 1'b0, `IFPC_OP_ERASE, r, r[7:0]);
         for (int i = 0; i < 4; i++) begin
            rnd(r);
            flash_op(b[0], 1'b0, `IFPC_OP_PROG, r, r[15:8] ^ 8'h3C);
            flash_op(b[0], 1'b0, `IFPC_OP_READ, r, 8'h00);
         end
      end
      flash_op(1'b0, 1'b0, `IFPC_OP_READ, r, 8'h00);
      n = req_cnt;
      flash_op(1'b0, 1'b1, `IFPC_OP_PROG, 16'hFFFF, 8'h00);
      flash_op(1'b0, 1'b0, 4'h7, 16'h0000, 8'h00);
      check(req_cnt, n);
      wr(`IFPC_IDX_CTRL, 8'h00);
      wr(`IFPC_IDX_PWR, 8'h02);
      check(cpu_idle_out, 1'b1);
      check(req_cnt, n);
      wake_in <= 1'b1;
      @(posedge core_clk_in);
      wake_in <= 1'b0;
      repeat (2) @(posedge core_clk_in);
      check(cpu_idle_out, 1'b0);
      wr(`IFPC_IDX_CTRL, 8'h03);
      wr(`IFPC_IDX_MODE, 8'h45);
      n = rst_cnt;
      // select bits written high too, so only the reset can clear them
      wr(`IFPC_IDX_CTRL, 8'h83);
      @(posedge core_clk_in);
      check(rst_cnt, n + 1);
      check(fetch_loader_out, 1'b0);
      rd_chk(`IFPC_IDX_CTRL, 8'h00);
      rd_chk(`IFPC_IDX_MODE, `IFPC_RST_MODE);
      give_verdict();
   end
endmodule // isp_flash_program_control_test

bind ifpc_program_control ifpc_program_control_sva #(.ADDR_W(ADDR_W)) ifpc_program_control_sva_inst (
   .core_clk_in, .rstn_in, .psel_in, .penable_in, .pwrite_in, .paddr_in, .pwdata_in,
   .pstrb_in, .prdata_out, .device_reset_out, .fetch_loader_out, .cpu_hold_out,
   .cpu_idle_out, .flash_req_out, .flash_op_out, .flash_addr_out, .flash_ce_n_out,
   .flash_done_in);
